// ---- hdl/wd_pkg.sv ----
package wd_pkg;

   // Special function register addresses.
   localparam logic [7:0] ADDR_RESTART   = 8'hA6;
   localparam logic [7:0] ADDR_PERIOD    = 8'hA7;

   // Restart key bytes, first and second.
   localparam logic [7:0] SEQ_FIRST      = 8'h1E;
   localparam logic [7:0] SEQ_SECOND     = 8'hE1;

   // Counter chain widths.
   localparam int         PRE_W          = 14;
   localparam int         CNT_W          = 7;
   localparam int         TOTAL_W        = PRE_W + CNT_W;

   // Period register layout and reset value.
   localparam int         CODE_W         = 3;
   localparam int         CODE_LSB       = 0;
   localparam logic [2:0] CODE_RST       = 3'h0;
   localparam logic [4:0] PERIOD_HI_READ = 5'h00;

   // Each prescaler step takes six watchdog clock periods.
   localparam logic [2:0] TICK_DIV       = 3'h6;

   // Reset pulse: 96 oscillator periods; the oscillator is clk.
   localparam int         OSC_PERIODS    = 96;
   localparam int         OSC_PERIOD_NS  = 8;
   localparam int         CLK_PERIOD_NS  = 8;
   localparam logic [6:0] RST_PULSE_CYC  =
      7'(OSC_PERIODS * OSC_PERIOD_NS / CLK_PERIOD_NS);

   // Counter value that ends the period for a time-out code.
   function automatic logic [CNT_W-1:0] timeout_target(
      input logic [CODE_W-1:0] code);
      timeout_target = CNT_W'((8'h01 << code) - 8'h01);
   endfunction : timeout_target

endpackage : wd_pkg

// ---- hdl/wd_count_if.sv ----
`timescale 1ns/1ps
interface wd_count_if;
   import wd_pkg::*;
   logic              tick;
   logic              clear;
   logic [CODE_W-1:0] code;
   logic              timeout;
   logic [PRE_W-1:0]  pre;
   logic [CNT_W-1:0]  cnt;
   modport ctrl (output tick, output clear, output code,
                 input timeout, input pre, input cnt);
   modport chain (input tick, input clear, input code,
                  output timeout, output pre, output cnt);
endinterface : wd_count_if

// ---- hdl/wd_counter.sv ----
`timescale 1ns/1ps
module wd_counter
   import wd_pkg::*;
(
   // Clock and synchronous reset.
   input wire logic   clk,
   input wire logic   rst_n,
   // Control side.
   wd_count_if.chain  cif
);

   logic [2:0]         div_q;
   logic [PRE_W-1:0]   pre_q;
   logic [CNT_W-1:0]   cnt_q;
   logic               step;
   logic [TOTAL_W-1:0] sum;
   logic [TOTAL_W-1:0] end_count;

   ////////////////////////////////////////////////////////////////////
   // Six watchdog clocks make one prescaler step.
   assign step = cif.tick && (div_q == TICK_DIV - 3'h1);
   assign sum  = {cnt_q, pre_q} + TOTAL_W'(1);

   // The step that brings the chain to target and all ones ends the
   // period, so a period is 6 * (2^14 * 2^n - 1) watchdog clocks.
   assign end_count   = {timeout_target(cif.code), {PRE_W{1'b1}}};
   assign cif.timeout = step && (sum == end_count);
   assign cif.pre = pre_q;
   assign cif.cnt = cnt_q;

   // Predivider; a clear restarts the whole period from zero.
   always_ff @(posedge clk) begin
      if (!rst_n || cif.clear) begin
         div_q <= 3'h0;
      end else if (step) begin
         div_q <= 3'h0;
      end else if (cif.tick) begin
         div_q <= div_q + 3'h1;
      end
   end

   // Prescaler cascaded into the programmable counter.
   always_ff @(posedge clk) begin
      if (!rst_n || cif.clear) begin
         {cnt_q, pre_q} <= '0;
      end else if (step) begin
         {cnt_q, pre_q} <= sum;
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_clear_zero;
      @(posedge clk) disable iff (!rst_n)
      cif.clear |=> (pre_q == '0) && (cnt_q == '0) && (div_q == 3'h0);
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("clear did not zero the chain");

   property p_timeout_point;
      @(posedge clk) disable iff (!rst_n)
      cif.timeout |-> (pre_q == {{(PRE_W-1){1'b1}}, 1'b0})
                      && (div_q == 3'h5)
                      && (cnt_q == timeout_target(cif.code));
   endproperty
   a_timeout_point: assert property (p_timeout_point)
      else $error("time-out at wrong count");

endmodule : wd_counter

// ---- hdl/watchdog_timeout_reset.sv ----
`timescale 1ns/1ps
// Function
// - 14-bit prescaler feeds 7-bit programmable counter.
// - Chip reset clears count, disables watchdog.
// - Bytes 1Eh then E1h clear and enable.
// - Once enabled, only chip reset disables.
// - Time-out drives reset high 96 oscillator periods.
// - Watchdog clock is oscillator halved or full.
// - Period is 6*(2^14*2^n-1) watchdog clocks.
// - Counting continues during Idle mode.
// - Power-down holds count; interrupt wake resumes.
// - Reset ending Power-down clears and disables.
// - Restart register write-only at A6h.
// - Period upper bits unused; code resets zero.
module watchdog_timeout_reset
   import wd_pkg::*;
(
   // Clock and synchronous chip reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Special function register port from the core.
   input  wire logic [7:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   output logic      [7:0] sfr_rdata,
   // Clock control and power state from the core.
   input  wire logic       wd_clock_select,
   input  wire logic       double_speed_mode,
   input  wire logic       power_down,
   // Reset pin drive and status.
   output logic            wd_reset_out,
   output logic            wd_enabled
);

   wd_count_if             cif ();

   logic                   half_q;
   logic                   full_rate;
   logic                   wd_tick;
   logic                   wr_restart;
   logic                   wr_period;
   logic                   seq_ok;
   logic                   armed_q;
   logic                   enabled_q;
   logic [CODE_W-1:0]      code_q;
   logic [7:0]             rdata_q;
   logic [6:0]             pulse_q;
   logic                   reset_q;

   ////////////////////////////////////////////////////////////////////
   // Watchdog clock enable.

   // Full oscillator rate only in double speed with select clear;
   // every other case halves it.
   assign full_rate = !wd_clock_select && double_speed_mode;

   // Free half-rate phase; it runs regardless of the watchdog state.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         half_q <= 1'b0;
      end else begin
         half_q <= !half_q;
      end
   end

   // Power-down stops the watchdog clock, so the chain holds its value
   // and resumes from it when an interrupt ends Power-down. Idle is
   // deliberately not looked at: the count keeps running there.
   assign wd_tick = !power_down && (full_rate || half_q)
                    && enabled_q;

   ////////////////////////////////////////////////////////////////////
   // Register decode.

   // Restart register is write-only; no read path exists for it.
   assign wr_restart = sfr_wr && (sfr_addr == ADDR_RESTART);
   assign wr_period  = sfr_wr && (sfr_addr == ADDR_PERIOD);

   // The second key byte counts only right after the first.
   assign seq_ok = wr_restart && armed_q
                   && (sfr_wdata == SEQ_SECOND);

   // Key detector: any restart write re-arms only on the first byte,
   // so a wrong second byte drops back to waiting.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
      end else if (wr_restart) begin
         armed_q <= (sfr_wdata == SEQ_FIRST);
      end
   end

   // Enable is sticky; no software write can drop it, and a reset
   // that ends Power-down clears it like any chip reset.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enabled_q <= 1'b0;
      end else if (seq_ok) begin
         enabled_q <= 1'b1;
      end
   end

   // Only the time-out code is stored; upper bits are not kept.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         code_q <= CODE_RST;
      end else if (wr_period) begin
         code_q <= sfr_wdata[CODE_LSB +: CODE_W];
      end
   end

   // Registered read data; unused bits and unmapped or write-only
   // addresses read as zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (sfr_rd) begin
         if (sfr_addr == ADDR_PERIOD) begin
            rdata_q <= {PERIOD_HI_READ, code_q};
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign sfr_rdata  = rdata_q;
   assign wd_enabled = enabled_q;

   ////////////////////////////////////////////////////////////////////
   // Counter chain.

   // The key sequence or a time-out restarts the period from zero.
   assign cif.tick  = wd_tick;
   assign cif.clear = seq_ok || cif.timeout;
   assign cif.code  = code_q;

   wd_counter u_counter (
      .clk   (clk),
      .rst_n (rst_n),
      .cif   (cif)
   );

   ////////////////////////////////////////////////////////////////////
   // Reset pulse generator.

   // A time-out loads the pulse length; the pin stays high until it
   // runs out. The chip reset that follows normally arrives earlier,
   // but the pulse is self-timed in case the pin is not looped back.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pulse_q <= 7'h00;
         reset_q <= 1'b0;
      end else if (cif.timeout) begin
         pulse_q <= RST_PULSE_CYC - 7'h01;
         reset_q <= 1'b1;
      end else if (pulse_q != 7'h00) begin
         pulse_q <= pulse_q - 7'h01;
      end else begin
         reset_q <= 1'b0;
      end
   end

   assign wd_reset_out = reset_q;

   ////////////////////////////////////////////////////////////////////
   // Checks.

   // Length of the current high run on the reset pin.
   logic [7:0] hi_len_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hi_len_q <= 8'h00;
      end else if (reset_q) begin
         hi_len_q <= hi_len_q + 8'h01;
      end else begin
         hi_len_q <= 8'h00;
      end
   end

   property p_reset_state;
      @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> !enabled_q && !reset_q && (code_q == 3'h0)
                       && (cif.pre == '0) && (cif.cnt == '0);
   endproperty
   a_reset_state: assert property (p_reset_state)
      else $error("state not cleared by reset");

   // A first key byte, a quiet cycle, then the second key byte.
   property p_key_enables;
      @(posedge clk) disable iff (!rst_n)
      (wr_restart && sfr_wdata == SEQ_FIRST)
      ##1 !wr_restart
      ##1 (wr_restart && sfr_wdata == SEQ_SECOND)
      |=> enabled_q && (cif.pre == '0) && (cif.cnt == '0);
   endproperty
   a_key_enables: assert property (p_key_enables)
      else $error("key sequence did not clear and enable");

   property p_bad_key;
      @(posedge clk) disable iff (!rst_n)
      (!enabled_q && armed_q && wr_restart
       && sfr_wdata != SEQ_SECOND)
      |=> !enabled_q && (armed_q == ($past(sfr_wdata) == SEQ_FIRST));
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("broken sequence took effect");

   property p_sticky_enable;
      @(posedge clk) disable iff (!rst_n)
      enabled_q |=> enabled_q;
   endproperty
   a_sticky_enable: assert property (p_sticky_enable)
      else $error("watchdog disabled without reset");

   // The pin falls only after the full pulse length.
   property p_pulse_len;
      @(posedge clk) disable iff (!rst_n)
      $fell(reset_q) |-> (hi_len_q == {1'b0, RST_PULSE_CYC});
   endproperty
   a_pulse_len: assert property (p_pulse_len)
      else $error("reset pulse not 96 cycles");

   property p_pulse_start;
      @(posedge clk) disable iff (!rst_n)
      cif.timeout |=> reset_q [*8];
   endproperty
   a_pulse_start: assert property (p_pulse_start)
      else $error("reset pin not raised on time-out");

   // A switch to full rate between two ticks is not a double tick.
   property p_half_rate;
      @(posedge clk) disable iff (!rst_n)
      (wd_tick && !full_rate) ##1 !full_rate |-> !wd_tick;
   endproperty
   a_half_rate: assert property (p_half_rate)
      else $error("halved watchdog clock ticked twice");

   // At full rate six clocks always hold one prescaler step, so the
   // chain must have moved; a lost tick would stall it.
   property p_full_rate;
      @(posedge clk) disable iff (!rst_n)
      (full_rate && enabled_q && !power_down && !cif.clear)[*7]
      |-> ({cif.cnt, cif.pre} != $past({cif.cnt, cif.pre}, 6));
   endproperty
   a_full_rate: assert property (p_full_rate)
      else $error("full-rate watchdog clock missed");

   property p_powerdown_hold;
      @(posedge clk) disable iff (!rst_n)
      (power_down && !seq_ok)
      |=> (cif.pre == $past(cif.pre)) && (cif.cnt == $past(cif.cnt));
   endproperty
   a_powerdown_hold: assert property (p_powerdown_hold)
      else $error("count moved in Power-down");

   // Read data of both register addresses.
   property p_restart_read;
      @(posedge clk) disable iff (!rst_n)
      (sfr_rd && sfr_addr == ADDR_RESTART) |=> (sfr_rdata == 8'h00);
   endproperty
   a_restart_read: assert property (p_restart_read)
      else $error("restart register not write-only");

   property p_period_read;
      @(posedge clk) disable iff (!rst_n)
      (sfr_rd && sfr_addr == ADDR_PERIOD)
      |=> (sfr_rdata == {5'h00, $past(code_q)});
   endproperty
   a_period_read: assert property (p_period_read)
      else $error("period read back wrong");

   // Eleven running clocks hold six ticks even at half rate, which is
   // the shortest span that is sure to contain a prescaler step.
   property p_idle_count;
      @(posedge clk) disable iff (!rst_n)
      (enabled_q && !power_down && !cif.clear && wd_tick)
      ##1 (!power_down && !cif.clear)[*6]
      ##1 (!power_down && !cif.clear)[*5]
      |-> ({cif.cnt, cif.pre} != $past({cif.cnt, cif.pre}, 11));
   endproperty
   a_idle_count: assert property (p_idle_count)
      else $error("count stalled while running");

   // Main scenarios that the bench is expected to reach.
   cov_enable: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(enabled_q));
   cov_half_tick: cover property (@(posedge clk) disable iff (!rst_n)
      enabled_q && !full_rate && wd_tick);
   cov_timeout: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(reset_q));
   cov_bad_key: cover property (@(posedge clk) disable iff (!rst_n)
      armed_q && wr_restart && sfr_wdata != SEQ_SECOND);
   cov_powerdown: cover property (@(posedge clk) disable iff (!rst_n)
      enabled_q && power_down ##1 !power_down);

endmodule : watchdog_timeout_reset

// ---- verif/tb_watchdog_timeout_reset.sv ----
`timescale 1ns/1ps
module tb_watchdog_timeout_reset;
   import wd_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Design signals and bench bookkeeping.
   logic        clk;
   logic        rst_n;
   logic [7:0]  sfr_addr;
   logic [7:0]  sfr_wdata;
   logic        sfr_wr;
   logic        sfr_rd;
   logic [7:0]  sfr_rdata;
   logic        wd_clock_select;
   logic        double_speed_mode;
   logic        power_down;
   logic        wd_reset_out;
   logic        wd_enabled;
   int          bad_count;
   int          checked;
   int          elapsed;
   int          n;
   logic [31:0] seed;
   logic [7:0]  val;

   watchdog_timeout_reset dut_u (
      .clk               (clk),
      .rst_n             (rst_n),
      .sfr_addr          (sfr_addr),
      .sfr_wdata         (sfr_wdata),
      .sfr_wr            (sfr_wr),
      .sfr_rd            (sfr_rd),
      .sfr_rdata         (sfr_rdata),
      .wd_clock_select   (wd_clock_select),
      .double_speed_mode (double_speed_mode),
      .power_down        (power_down),
      .wd_reset_out      (wd_reset_out),
      .wd_enabled        (wd_enabled)
   );

   // The clock toggles every half period of 4 ns.
   initial clk = 1'b0;
   always #4 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   // Random source, comparison and closing.

   // Xorshift keeps the run repeatable without relying on the simulator.
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : xs

   // Watchdog clocks from a clear to time-out for a period code.
   function automatic int timeout_ticks(input int code);
      return 6 * ((2 ** (PRE_W + code)) - 1);
   endfunction : timeout_ticks

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   ////////////////////////////////////////////////////////////////////////
   // Bus tasks; each starts and ends 1 ns after a rising edge.

   task automatic step(input int cycles);
      repeat (cycles) begin
         @(posedge clk);
         #1;
         elapsed++;
      end
   endtask : step

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      step(1);
      sfr_wr    = 1'b0;
      step(1);
   endtask : wr

   // Data is sampled one full cycle later so the register has landed.
   task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      step(1);
      sfr_rd   = 1'b0;
      step(1);
      check(sfr_rdata, exp);
   endtask : rd_check

   task automatic next_rand();
      seed = xs(seed);
   endtask : next_rand

   // A key byte pair; the bench's own stimulus keeps the write order.
   task automatic key();
      wr(ADDR_RESTART, SEQ_FIRST);
      wr(ADDR_RESTART, SEQ_SECOND);
   endtask : key

   // A hang is cut short well beyond the expected run of ~101k cycles.
   initial begin
      #(8 * 130000);
      bad_count++;
      conclude();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      bad_count = 0;
      checked = 0;
      elapsed = 0;
      seed = 32'hEE0E05DF;
      rst_n = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      wd_clock_select = 1'b0;
      double_speed_mode = 1'b1;
      power_down = 1'b0;
      step(12);
      rst_n = 1'b1;
      check({7'h00, wd_enabled}, 8'h00);
      check({7'h00, wd_reset_out}, 8'h00);
      rd_check(ADDR_PERIOD, 8'h00);
      rd_check(ADDR_RESTART, 8'h00);
      // Every code, upper bits left clear as software must keep them.
      for (int i = 0; i < 8; i++) begin
         next_rand();
         wr(ADDR_PERIOD, {5'h00, 3'(i)});
         wr(8'hA8 + seed[10:8], seed[23:16]);
         rd_check(ADDR_PERIOD, {5'h00, 3'(i)});
      end
      // Random restart bytes that never form the key leave it disabled.
      for (int i = 0; i < 8; i++) begin
         next_rand();
         val = (seed[7:0] == SEQ_FIRST) ? 8'h1F : seed[7:0];
         wr(ADDR_RESTART, val);
      end
      wr(ADDR_RESTART, SEQ_FIRST);
      wr(ADDR_RESTART, 8'h55);
      wr(ADDR_RESTART, SEQ_SECOND);
      check({7'h00, wd_enabled}, 8'h00);
      wr(ADDR_PERIOD, 8'h00);
      key();
      check({7'h00, wd_enabled}, 8'h01);
      // Nothing written afterwards may stop it.
      for (int i = 0; i < 6; i++) begin
         next_rand();
         wr(ADDR_RESTART, seed[7:0]);
         wr(ADDR_PERIOD, {5'h00, seed[10:8]});
      end
      wr(ADDR_PERIOD, 8'h00);
      check({7'h00, wd_enabled}, 8'h01);
      // Clear, then shape the rate: half rate, standard mode, frozen.
      step(500);
      key();
      elapsed = 0;
      wd_clock_select = 1'b1;
      step(1000);
      wd_clock_select = 1'b0;
      double_speed_mode = 1'b0;
      step(1000);
      double_speed_mode = 1'b1;
      wr(ADDR_RESTART, SEQ_FIRST);
      wr(ADDR_RESTART, 8'h55);
      wr(ADDR_RESTART, SEQ_SECOND);
      power_down = 1'b1;
      step(1000);
      check({7'h00, wd_enabled}, 8'h01);
      power_down = 1'b0;
      // Time-out comes 2000 lost ticks late, less the one tick taken
      // before elapsed was zeroed; a slip of one step shows here.
      while (wd_reset_out !== 1'b1 && elapsed < 101000)
         step(1);
      n = elapsed;
      check({7'h00, n == timeout_ticks(0) + 1999}, 8'h01);
      check({7'h00, n >= 100292}, 8'h01);
      // The pulse is held exactly 96 oscillator periods.
      n = 0;
      while (wd_reset_out === 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      check(8'(n), 8'(RST_PULSE_CYC));
      check({7'h00, wd_enabled}, 8'h01);
      // A reset that ends power-down clears and disables.
      key();
      power_down = 1'b1;
      step(20);
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      power_down = 1'b0;
      check({7'h00, wd_enabled}, 8'h00);
      check({7'h00, wd_reset_out}, 8'h00);
      rd_check(ADDR_PERIOD, 8'h00);
      conclude();
   end

endmodule : tb_watchdog_timeout_reset
